// ===== rtl/pmir_pkg.sv
// constants for the payload mode and i2c remap register bank
`default_nettype none
package pmir_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PASS_CFG = 10'h003;
    localparam logic [9:0] IDX_MODE_SEL = 10'h005;
    localparam logic [9:0] IDX_RECV_ADDR = 10'h006;
    localparam logic [9:0] IDX_RECV_ALIAS = 10'h007;
    localparam logic [9:0] IDX_TGT_ADDR = 10'h008;
    localparam logic [9:0] IDX_TGT_ALIAS = 10'h009;
    localparam logic [9:0] IDX_STATUS = 10'h00c;

    // payload mode select fields
    localparam int MODE_OVR_BIT = 5;
    localparam int MODE_CUR_BIT = 4;
    localparam int STRAP_12_BIT = 3;
    localparam int STRAP_10_BIT = 2;
    localparam int SEL_12_BIT = 1;
    localparam int SEL_10_BIT = 0;
    localparam logic [7:0] MODE_SEL_RST = 8'h00;
    localparam logic [7:0] MODE_SEL_RW_MASK = 8'he3;

    // address style registers: 7-bit field in 7:1, flag in bit 0
    localparam int ID_MSB = 7;
    localparam int ID_LSB = 1;
    localparam int HOLD_BIT = 0;
    localparam logic [7:0] ADDR_REG_RST = 8'h00;
    localparam logic [6:0] ID_ZERO = 7'h00;

    // pass-through config and general status
    localparam int PASS_EN_BIT = 2;
    localparam logic PASS_EN_RST = 1'b1;
    localparam int LOCK_BIT = 4;

    // alias map entries
    localparam int MAP_RECV = 0;
    localparam int MAP_TGT = 1;
    localparam int MAP_COUNT = 2;
endpackage
`default_nettype wire

// ===== rtl/pmir_mode_sel.sv
// payload width selection between back channel and software override
`default_nettype none
module pmir_mode_sel (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // selection sources
    input wire logic override,
    input wire logic sw_sel_12b,
    input wire logic sw_sel_10b,
    input wire logic bc_sel_12b,
    input wire logic bc_sel_10b,
    // active payload mode
    output logic twelve_bit_payload_sel,
    output logic ten_bit_payload_sel
);
    logic mode_12b_nxt;
    logic mode_10b_nxt;

    // both software bits set is left as written; software keeps them apart
    always_comb begin
        if (override) begin
            mode_12b_nxt = sw_sel_12b;
            mode_10b_nxt = sw_sel_10b;
        end else begin
            mode_12b_nxt = bc_sel_12b;
            mode_10b_nxt = bc_sel_10b;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            twelve_bit_payload_sel <= 1'b0;
            ten_bit_payload_sel <= 1'b0;
        end else begin
            twelve_bit_payload_sel <= mode_12b_nxt;
            ten_bit_payload_sel <= mode_10b_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pmir_alias_map.sv
// one alias decode entry: match an i2c address and give its real address
`default_nettype none
module pmir_alias_map (
    // decode enables and table contents
    input wire logic enable,
    input wire logic [6:0] alias_addr,
    input wire logic [6:0] dest_addr,
    // incoming address
    input wire logic [6:0] in_addr,
    // decode result
    output logic hit,
    output logic [6:0] out_addr
);
    logic alias_live;
    logic dest_live;

    // zero in either field shuts the path
    assign alias_live = (alias_addr != pmir_pkg::ID_ZERO);
    assign dest_live = (dest_addr != pmir_pkg::ID_ZERO);
    assign hit = enable && alias_live && dest_live && (in_addr == alias_addr);
    assign out_addr = dest_addr;
endmodule
`default_nettype wire

// ===== rtl/pmir_regs.sv
// payload mode and i2c remap register bank with apb slave
`default_nettype none
// What this block does
// - with override set the payload width comes from software bits, else from the back channel.
// - bit 4 of the mode register reads 1 while the back-channel mode is current.
// - bits 3 and 2 report the strapped 12-bit and 10-bit modes read-only.
// - software bit 1 picks 12-bit payload, effective only under override.
// - software bit 0 picks 10-bit payload, effective only under override.
// - bits 7:1 of the receiver address register hold its 7-bit address, reset zero.
// - a zero receiver address stops all forwarding to the receiver.
// - after link lock the receiver address loads from the control channel.
// - the hold bit stops that automatic load and keeps the written value.
// - accesses to the receiver alias are rewritten to the receiver address; alias zero disables.
// - accesses to the target alias are rewritten to the stored target address.
// - a zero target address blocks all forwarding to the target.
// - the target alias sits in bits 7:1 and zero disables the target path.
// - alias forwarding works only while pass-through is enabled, which resets to on.
// - a read-only lock flag shows the receive lock that triggers the automatic load.
module pmir_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // back channel mode and id
    input wire logic bc_mode_12b,
    input wire logic bc_mode_10b,
    input wire logic bc_mode_current,
    input wire logic [6:0] bc_remote_id,
    input wire logic bc_remote_id_valid,
    // straps and link status
    input wire logic strap_mode_12b,
    input wire logic strap_mode_10b,
    input wire logic rx_lock,
    // local i2c address decode request
    input wire logic i2c_req,
    input wire logic [6:0] i2c_addr,
    // forwarded request toward the control channel
    output logic fwd_req,
    output logic [6:0] fwd_addr,
    output logic fwd_to_target,
    output logic fwd_drop,
    // active payload mode
    output logic twelve_bit_payload_sel,
    output logic ten_bit_payload_sel
);
    logic [7:0] mode_sel_r;
    logic [7:0] recv_addr_r;
    logic [7:0] recv_alias_r;
    logic [7:0] tgt_addr_r;
    logic [7:0] tgt_alias_r;
    logic pass_en_r;
    logic mode_cur_r;
    logic strap_12_r;
    logic strap_10_r;
    logic lock_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic [9:0] idx;
    logic aligned;
    logic setup;
    logic wr_en;
    logic wr_mode_sel;
    logic wr_pass_cfg;
    logic wr_recv_addr;
    logic wr_recv_alias;
    logic wr_tgt_addr;
    logic wr_tgt_alias;
    logic lane0;
    logic [7:0] wbyte;
    logic auto_load;
    logic [6:0] map_alias [pmir_pkg::MAP_COUNT];
    logic [6:0] map_dest [pmir_pkg::MAP_COUNT];
    logic map_hit [pmir_pkg::MAP_COUNT];
    logic [6:0] map_out [pmir_pkg::MAP_COUNT];
    logic fwd_req_r;
    logic [6:0] fwd_addr_r;
    logic fwd_tgt_r;
    logic fwd_drop_r;

    // bus decode
    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign lane0 = pstrb[0];
    assign wbyte = pwdata[7:0];
    // no wait state: read data is latched in setup, answer in the first access cycle
    assign wr_en = psel && penable && pwrite && lane0 && !pslverr_r;

    // one strobe per register, so each store sees a single decode
    assign wr_mode_sel = wr_en && (idx == pmir_pkg::IDX_MODE_SEL);
    assign wr_pass_cfg = wr_en && (idx == pmir_pkg::IDX_PASS_CFG);
    assign wr_recv_addr = wr_en && (idx == pmir_pkg::IDX_RECV_ADDR);
    assign wr_recv_alias = wr_en && (idx == pmir_pkg::IDX_RECV_ALIAS);
    assign wr_tgt_addr = wr_en && (idx == pmir_pkg::IDX_TGT_ADDR);
    assign wr_tgt_alias = wr_en && (idx == pmir_pkg::IDX_TGT_ALIAS);
    assign pready = psel && penable;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // read mux and address check
    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (!aligned) begin
            err_nxt = 1'b1;
        end else begin
            unique case (idx)
                pmir_pkg::IDX_PASS_CFG: begin
                    rd_nxt[pmir_pkg::PASS_EN_BIT] = pass_en_r;
                end
                pmir_pkg::IDX_MODE_SEL: begin
                    rd_nxt[7:0] = mode_sel_r & pmir_pkg::MODE_SEL_RW_MASK;
                    rd_nxt[pmir_pkg::MODE_CUR_BIT] = mode_cur_r;
                    rd_nxt[pmir_pkg::STRAP_12_BIT] = strap_12_r;
                    rd_nxt[pmir_pkg::STRAP_10_BIT] = strap_10_r;
                end
                pmir_pkg::IDX_RECV_ADDR: begin
                    rd_nxt[7:0] = recv_addr_r;
                end
                pmir_pkg::IDX_RECV_ALIAS: begin
                    rd_nxt[7:0] = recv_alias_r;
                end
                pmir_pkg::IDX_TGT_ADDR: begin
                    rd_nxt[7:0] = tgt_addr_r;
                end
                pmir_pkg::IDX_TGT_ALIAS: begin
                    rd_nxt[7:0] = tgt_alias_r;
                end
                pmir_pkg::IDX_STATUS: begin
                    rd_nxt[pmir_pkg::LOCK_BIT] = lock_r;
                end
                default: begin
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= err_nxt;
        end
    end

    // status inputs registered so reads see a stable copy
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_cur_r <= 1'b0;
            strap_12_r <= 1'b0;
            strap_10_r <= 1'b0;
            lock_r <= 1'b0;
        end else begin
            mode_cur_r <= bc_mode_current;
            strap_12_r <= strap_mode_12b;
            strap_10_r <= strap_mode_10b;
            lock_r <= rx_lock;
        end
    end

    // mode select: read-only bits 4:2 are never stored
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_sel_r <= pmir_pkg::MODE_SEL_RST;
        end else if (wr_mode_sel) begin
            mode_sel_r <= wbyte & pmir_pkg::MODE_SEL_RW_MASK;
        end
    end

    // pass-through enable, on after reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pass_en_r <= pmir_pkg::PASS_EN_RST;
        end else if (wr_pass_cfg) begin
            pass_en_r <= wbyte[pmir_pkg::PASS_EN_BIT];
        end
    end

    // automatic id load while locked unless held
    assign auto_load = lock_r && bc_remote_id_valid
        && !recv_addr_r[pmir_pkg::HOLD_BIT];

    // load from the channel wins over a colliding software write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            recv_addr_r <= pmir_pkg::ADDR_REG_RST;
        end else if (auto_load) begin
            recv_addr_r[pmir_pkg::ID_MSB:pmir_pkg::ID_LSB] <= bc_remote_id;
        end else if (wr_recv_addr) begin
            recv_addr_r <= wbyte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            recv_alias_r <= pmir_pkg::ADDR_REG_RST;
        end else if (wr_recv_alias) begin
            recv_alias_r <= wbyte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tgt_addr_r <= pmir_pkg::ADDR_REG_RST;
        end else if (wr_tgt_addr) begin
            tgt_addr_r <= wbyte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tgt_alias_r <= pmir_pkg::ADDR_REG_RST;
        end else if (wr_tgt_alias) begin
            tgt_alias_r <= wbyte;
        end
    end

    // alias table contents
    assign map_alias[pmir_pkg::MAP_RECV] =
        recv_alias_r[pmir_pkg::ID_MSB:pmir_pkg::ID_LSB];
    assign map_dest[pmir_pkg::MAP_RECV] =
        recv_addr_r[pmir_pkg::ID_MSB:pmir_pkg::ID_LSB];
    assign map_alias[pmir_pkg::MAP_TGT] =
        tgt_alias_r[pmir_pkg::ID_MSB:pmir_pkg::ID_LSB];
    assign map_dest[pmir_pkg::MAP_TGT] =
        tgt_addr_r[pmir_pkg::ID_MSB:pmir_pkg::ID_LSB];

    // zero alias or zero destination closes an entry
    genvar gi;
    generate
        for (gi = 0; gi < pmir_pkg::MAP_COUNT; gi++) begin : g_map
            pmir_alias_map u_map (
                .enable(pass_en_r),
                .alias_addr(map_alias[gi]),
                .dest_addr(map_dest[gi]),
                .in_addr(i2c_addr),
                .hit(map_hit[gi]),
                .out_addr(map_out[gi])
            );
        end
    endgenerate

    // receiver entry has priority if both aliases are programmed alike
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fwd_req_r <= 1'b0;
            fwd_addr_r <= pmir_pkg::ID_ZERO;
            fwd_tgt_r <= 1'b0;
            fwd_drop_r <= 1'b0;
        end else begin
            fwd_req_r <= 1'b0;
            fwd_drop_r <= 1'b0;
            if (i2c_req) begin
                if (map_hit[pmir_pkg::MAP_RECV]) begin
                    fwd_req_r <= 1'b1;
                    fwd_addr_r <= map_out[pmir_pkg::MAP_RECV];
                    fwd_tgt_r <= 1'b0;
                end else if (map_hit[pmir_pkg::MAP_TGT]) begin
                    fwd_req_r <= 1'b1;
                    fwd_addr_r <= map_out[pmir_pkg::MAP_TGT];
                    fwd_tgt_r <= 1'b1;
                end else begin
                    fwd_drop_r <= 1'b1;
                end
            end
        end
    end

    assign fwd_req = fwd_req_r;
    assign fwd_addr = fwd_addr_r;
    assign fwd_to_target = fwd_tgt_r;
    assign fwd_drop = fwd_drop_r;

    // payload width
    pmir_mode_sel u_mode (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .override(mode_sel_r[pmir_pkg::MODE_OVR_BIT]),
        .sw_sel_12b(mode_sel_r[pmir_pkg::SEL_12_BIT]),
        .sw_sel_10b(mode_sel_r[pmir_pkg::SEL_10_BIT]),
        .bc_sel_12b(bc_mode_12b),
        .bc_sel_10b(bc_mode_10b),
        .twelve_bit_payload_sel(twelve_bit_payload_sel),
        .ten_bit_payload_sel(ten_bit_payload_sel)
    );
endmodule
`default_nettype wire

// ===== sim/pmir_regs_chk.sv
// port assertions for the remap register bank
`default_nettype none
module pmir_regs_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // i2c decode
    input wire logic i2c_req,
    input wire logic [6:0] i2c_addr,
    input wire logic fwd_req,
    input wire logic [6:0] fwd_addr,
    input wire logic fwd_to_target,
    input wire logic fwd_drop,
    // payload mode
    input wire logic bc_mode_12b,
    input wire logic bc_mode_10b,
    input wire logic twelve_bit_payload_sel,
    input wire logic ten_bit_payload_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic acc;
    assign acc = psel && penable;
    ready_access_a: assert property (acc |-> pready)
        else $error("no ready in access cycle");
    read_upper_a: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    unaligned_err_a: assert property (
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && prdata == 0)
        else $error("unaligned access not refused");
    fwd_answer_a: assert property (i2c_req |=> fwd_req != fwd_drop)
        else $error("decode gave no single answer");
    fwd_quiet_a: assert property (!i2c_req |=> !fwd_req && !fwd_drop)
        else $error("decode answer without request");
    zero_alias_a: assert property (i2c_req && i2c_addr == 7'h00 |=> fwd_drop)
        else $error("address zero was forwarded");
    dest_hold_a: assert property (
        !fwd_req |-> $stable(fwd_addr) && $stable(fwd_to_target))
        else $error("destination moved without a hit");
    // mode only moves on a back channel change or a register access
    mode_steady_a: assert property (
        !acc ##1 (!acc && $stable(bc_mode_12b) && $stable(bc_mode_10b))
        |=> $stable(twelve_bit_payload_sel) && $stable(ten_bit_payload_sel))
        else $error("payload mode moved without cause");
endmodule
`default_nettype wire

// ===== sim/pmir_far_end.sv
// far end model: remote receiver giving lock, id and mode status
`default_nettype none
module pmir_far_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // bench control
    input wire logic link_up,
    input wire logic [6:0] my_id,
    // back channel toward the device
    output logic rx_lock,
    output logic bc_mode_current,
    output logic [6:0] bc_remote_id,
    output logic bc_remote_id_valid
);
    logic [3:0] tick_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !link_up) begin
            tick_r <= 4'h0;
            rx_lock <= 1'b0;
        end else begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == 4'hf) rx_lock <= 1'b1;
        end
    end
    // id repeats while locked; a moving pattern otherwise, never a stale id
    always_ff @(posedge core_clk) begin
        bc_remote_id_valid <= rx_lock && tick_r[2:0] == 3'h0;
        bc_remote_id <= rx_lock ? my_id : (sys_rst ? 7'h55 : ~bc_remote_id);
        bc_mode_current <= rx_lock;
    end
endmodule
`default_nettype wire

// ===== sim/pmir_regs_test.sv
// bench for the payload mode and i2c remap register bank
`default_nettype none
module pmir_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic bc_mode_12b, bc_mode_10b, bc_mode_current, bc_remote_id_valid;
    logic [6:0] bc_remote_id, i2c_addr, fwd_addr, my_id;
    logic strap_mode_12b, strap_mode_10b, rx_lock, i2c_req, link_up;
    logic fwd_req, fwd_to_target, fwd_drop, twelve_bit_payload_sel, ten_bit_payload_sel;
    int mismatches, n_checks, cycles;

    pmir_regs dut (.core_clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .bc_mode_12b,
        .bc_mode_10b, .bc_mode_current, .bc_remote_id, .bc_remote_id_valid,
        .strap_mode_12b, .strap_mode_10b, .rx_lock, .i2c_req, .i2c_addr,
        .fwd_req, .fwd_addr, .fwd_to_target, .fwd_drop, .twelve_bit_payload_sel,
        .ten_bit_payload_sel);
    pmir_far_end far (.core_clk, .sys_rst, .link_up, .my_id, .rx_lock,
        .bc_mode_current, .bc_remote_id, .bc_remote_id_valid);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk_val({err, rd}, {1'b0, 24'h0, exp});
    endtask

    task automatic mode_chk(input logic [1:0] exp);
        repeat (3) @(posedge core_clk);
        #1;
        chk_val(33'({twelve_bit_payload_sel, ten_bit_payload_sel}), 33'(exp));
        @(posedge core_clk);
    endtask

    // exp holds hit, target flag and destination address
    task automatic i2c(input logic [6:0] a, input logic [8:0] exp);
        @(posedge core_clk);
        i2c_req <= 1'b1;
        i2c_addr <= a;
        @(posedge core_clk);
        i2c_req <= 1'b0;
        #1;
        if (exp[8]) chk_val(33'({fwd_req, fwd_drop, fwd_to_target, fwd_addr}),
            33'({2'b10, exp[7:0]}));
        else chk_val(33'({fwd_req, fwd_drop}), 33'(2'b01));
    endtask

    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, i2c_req, link_up} = '0;
        {bc_mode_12b, bc_mode_10b, strap_mode_10b} = '0;
        strap_mode_12b = 1'b1;
        {paddr, pwdata, i2c_addr} = '0;
        pstrb = 4'hf;
        my_id = 7'h2a;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(12'h014, 8'h08);
        rd_chk(12'h018, 8'h00);
        rd_chk(12'h01c, 8'h00);
        rd_chk(12'h020, 8'h00);
        rd_chk(12'h024, 8'h00);
        rd_chk(12'h00c, 8'h04);
        apb(1'b0, 12'h010, 8'h00);
        chk_val({err, rd}, {1'b1, 32'h0});
        bc_mode_12b <= 1'b1;
        mode_chk(2'b10);
        apb(1'b1, 12'h014, 8'h21);
        mode_chk(2'b01);
        apb(1'b1, 12'h014, 8'h22);
        mode_chk(2'b10);
        {bc_mode_12b, bc_mode_10b} <= 2'b01;
        mode_chk(2'b10);
        apb(1'b1, 12'h014, 8'h02);
        mode_chk(2'b01);
        pstrb <= 4'h0;
        apb(1'b1, 12'h014, 8'h21);
        pstrb <= 4'hf;
        {strap_mode_12b, strap_mode_10b} <= 2'b01;
        apb(1'b1, 12'h016, 8'h21);
        chk_val({err, rd}, {1'b1, 32'h0});
        rd_chk(12'h014, 8'h06);
        // lock brings the id in from the far end
        link_up <= 1'b1;
        repeat (40) @(posedge core_clk);
        rd_chk(12'h030, 8'h10);
        rd_chk(12'h018, 8'h54);
        rd_chk(12'h014, 8'h16);
        // link dropped first so no same-cycle auto load can eat the write
        link_up <= 1'b0;
        repeat (4) @(posedge core_clk);
        apb(1'b1, 12'h018, 8'h67);
        link_up <= 1'b1;
        repeat (40) @(posedge core_clk);
        rd_chk(12'h018, 8'h67);
        i2c(7'h00, 9'h000);
        i2c(7'h40, 9'h000);
        apb(1'b1, 12'h01c, 8'h80);
        i2c(7'h40, {2'b10, 7'h33});
        apb(1'b1, 12'h024, 8'ha0);
        i2c(7'h50, 9'h000);
        apb(1'b1, 12'h020, 8'h58);
        i2c(7'h50, {2'b11, 7'h2c});
        i2c(7'h41, 9'h000);
        apb(1'b1, 12'h018, 8'h01);
        i2c(7'h40, 9'h000);
        apb(1'b1, 12'h00c, 8'h00);
        i2c(7'h50, 9'h000);
        summarize();
    end
endmodule

bind pmir_regs pmir_regs_chk chk (.core_clk, .sys_rst, .paddr, .psel,
    .penable, .prdata, .pready, .pslverr, .i2c_req, .i2c_addr, .fwd_req,
    .fwd_addr, .fwd_to_target, .fwd_drop, .bc_mode_12b, .bc_mode_10b,
    .twelve_bit_payload_sel, .ten_bit_payload_sel);
`default_nettype wire
